// ==== design/adc_conv_map.svh ====
// Address map, field positions, reset values and sequencing counts
// for the conversion control block.
// Assumes a 32-bit APB register bus with word-aligned registers.
`ifndef ADC_CONV_MAP_SVH
`define ADC_CONV_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define ADC_APB_AW         8
`define ADC_OFS_CTRL       8'h00
`define ADC_OFS_SELECT     8'h04
`define ADC_OFS_RES_HIGH   8'h08
`define ADC_OFS_RES_LOW    8'h0c
`define ADC_OFS_IRQ        8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ADC_CTRL_CH_LSB    0
`define ADC_CTRL_START     6
`define ADC_CTRL_DONE_N    7
`define ADC_SEL_DIV_LSB    0
`define ADC_SEL_PCFG_LSB   4
`define ADC_RESLO_LSB      4
`define ADC_IRQ_FLAG       0
`define ADC_IRQ_ENABLE     1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ADC_RST_CH         4'h0
`define ADC_RST_DIV        2'h3
`define ADC_RST_PCFG       4'h0
`define ADC_RST_DONE_N     1'b1
`define ADC_RST_RESULT     12'h000

// ---------------------------------------------------------------
// Sequencing, counted in converter clock periods
// ---------------------------------------------------------------
`define ADC_TICK_SAMPLE    4'h0
`define ADC_TICK_MSB       4'h1
`define ADC_TICK_LSB       4'hc
`define ADC_TICK_LAST      4'hf
`define ADC_PCFG_ALL       4'hf
`define ADC_PIN_COUNT      16
`define ADC_RES_MSB        4'hb

`endif

// ==== design/adc_conv_pkg.sv ====
// Types shared by the conversion control block.
// Assumes adc_conv_map.svh supplies the numeric constants.
`default_nettype none

package adc_conv_pkg;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_hold = 2'b01,
    st_conv = 2'b10
  } conv_state_t;

  // ---------------------------------------------------------------
  // Drive towards the analog converter macro
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        power_down;
    logic        reset;
    logic        sample;
    logic [11:0] dac_code;
  } conv_drive_t;

  // ---------------------------------------------------------------
  // Drive towards the shared port pins
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] analog_en;
    logic [15:0] pullup_cut;
    logic [15:0] dir_force_in;
  } pin_drive_t;

endpackage

`default_nettype wire

// ==== design/adc_conversion_control.sv ====
// Conversion control for one 12-bit successive approximation converter.
// Assumes an APB master on mclk and an analog macro that offers a mux,
// a trial DAC, a sampler and an asynchronous comparator output.
`timescale 1ns/10ps
`include "adc_conv_map.svh"
`default_nettype none

module adc_conversion_control #(
  parameter int DIV_RATIO_0 = 4,
  parameter int DIV_RATIO_1 = 8,
  parameter int DIV_RATIO_2 = 16,
  parameter int DIV_RATIO_3 = 32,
  parameter int PIN_STEP    = 1
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  // APB slave
  input  wire logic [`ADC_APB_AW-1:0]     paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Analog converter macro
  input  wire logic                       cmp_in,
  output adc_conv_pkg::conv_drive_t       conv_drive,
  output logic      [15:0]                channel_route,
  // Shared port pins
  output adc_conv_pkg::pin_drive_t        pin_drive,
  // Interrupt request towards the interrupt controller
  output logic                            conv_irq
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Smallest ratio must leave room for the comparator synchroniser
  generate
    if (DIV_RATIO_0 < 4 || DIV_RATIO_1 <= DIV_RATIO_0 ||
        DIV_RATIO_2 <= DIV_RATIO_1 || DIV_RATIO_3 <= DIV_RATIO_2 ||
        DIV_RATIO_3 > 256) begin : g_bad_ratio
      $error("divider ratios must rise strictly from at least 4 up to 256");
    end
    if (PIN_STEP < 1 || PIN_STEP > `ADC_PIN_COUNT) begin : g_bad_step
      $error("pin step must lie between 1 and 16");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  // Reset clock select, split bit by bit below
  localparam logic [1:0]     RST_DIV = `ADC_RST_DIV;
  logic [3:0]                channel_select;
  logic                      start_bit;
  logic                      conv_done_n;
  logic                      clk_div_sel_hi;
  logic                      clk_div_sel_lo;
  logic [3:0]                analog_pin_config;
  logic [11:0]               result;
  logic                      irq_flag;
  logic                      irq_enable;

  // Sequencer state
  adc_conv_pkg::conv_state_t state;
  adc_conv_pkg::conv_state_t next_state;
  logic                      start_prev;
  logic [7:0]                div_cnt;
  logic [7:0]                div_ratio;
  logic                      conv_tick;
  logic [3:0]                tick_cnt;
  logic [3:0]                bit_idx;
  logic [11:0]               trial;
  logic                      finish;

  // Comparator synchroniser
  logic                      cmp_meta;
  logic                      cmp_sync;

  // Bus decode
  logic                      setup_phase;
  logic                      wr_access;
  logic                      addr_hit;
  logic [15:0]               pin_mask;
  logic                      powered;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Zero wait states: every access phase completes at once
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & pstrb[0] & addr_hit;
  assign pready      = psel & penable;
  assign pslverr     = psel & penable & ~addr_hit;

  // Only the five documented words answer without error
  always_comb begin
    case (paddr)
      `ADC_OFS_CTRL,
      `ADC_OFS_SELECT,
      `ADC_OFS_RES_HIGH,
      `ADC_OFS_RES_LOW,
      `ADC_OFS_IRQ: addr_hit = 1'b1;
      default:      addr_hit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle, so prdata comes from a flop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        `ADC_OFS_CTRL: begin
          prdata[`ADC_CTRL_CH_LSB +: 4] <= channel_select;
          prdata[`ADC_CTRL_START]       <= start_bit;
          prdata[`ADC_CTRL_DONE_N]      <= conv_done_n;
        end
        `ADC_OFS_SELECT: begin
          prdata[`ADC_SEL_DIV_LSB +: 2]  <= {clk_div_sel_hi, clk_div_sel_lo};
          prdata[`ADC_SEL_PCFG_LSB +: 4] <= analog_pin_config;
        end
        `ADC_OFS_RES_HIGH: begin
          prdata[7:0] <= result[11:4];
        end
        `ADC_OFS_RES_LOW: begin
          prdata[`ADC_RESLO_LSB +: 4] <= result[3:0];
        end
        `ADC_OFS_IRQ: begin
          prdata[`ADC_IRQ_FLAG]   <= irq_flag;
          prdata[`ADC_IRQ_ENABLE] <= irq_enable;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Software-written control fields
  // ---------------------------------------------------------------
  // Control word: channel and start bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel_select <= `ADC_RST_CH;
      start_bit      <= 1'b0;
    end else if (wr_access && paddr == `ADC_OFS_CTRL) begin
      channel_select <= pwdata[`ADC_CTRL_CH_LSB +: 4];
      start_bit      <= pwdata[`ADC_CTRL_START];
    end
  end

  // Clock select and pin configuration word
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clk_div_sel_hi    <= RST_DIV[1];
      clk_div_sel_lo    <= RST_DIV[0];
      analog_pin_config <= `ADC_RST_PCFG;
    end else if (wr_access && paddr == `ADC_OFS_SELECT) begin
      clk_div_sel_hi    <= pwdata[`ADC_SEL_DIV_LSB + 1];
      clk_div_sel_lo    <= pwdata[`ADC_SEL_DIV_LSB];
      analog_pin_config <= pwdata[`ADC_SEL_PCFG_LSB +: 4];
    end
  end

  // ---------------------------------------------------------------
  // Pin configuration
  // ---------------------------------------------------------------
  // Code 1111 takes all pins; lower codes grow a block from pin 0
  always_comb begin
    int count;
    count = 0;
    if (analog_pin_config == `ADC_PCFG_ALL) begin
      count = `ADC_PIN_COUNT;
    end else begin
      count = int'(analog_pin_config) * PIN_STEP;
      if (count > `ADC_PIN_COUNT) begin
        count = `ADC_PIN_COUNT;
      end
    end
    for (int i = 0; i < `ADC_PIN_COUNT; i++) begin
      pin_mask[i] = (i < count);
    end
  end

  // Zero config leaves plain I/O and powers the converter off
  assign powered = (analog_pin_config != 4'h0);

  // Pin drive registered so the port logic sees a clean level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_drive <= '0;
    end else begin
      pin_drive.analog_en    <= pin_mask;
      pin_drive.pullup_cut   <= pin_mask;
      pin_drive.dir_force_in <= pin_mask;
    end
  end

  // One-hot mux select; never more than one input reaches the converter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel_route <= 16'h0000;
    end else begin
      channel_route <= powered ? (16'h0001 << channel_select) : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Converter clock divider
  // ---------------------------------------------------------------
  // Ratio table; code 00 is the fastest setting
  always_comb begin
    case ({clk_div_sel_hi, clk_div_sel_lo})
      2'h0:    div_ratio = 8'(DIV_RATIO_0 - 1);
      2'h1:    div_ratio = 8'(DIV_RATIO_1 - 1);
      2'h2:    div_ratio = 8'(DIV_RATIO_2 - 1);
      2'h3:    div_ratio = 8'(DIV_RATIO_3 - 1);
      default: div_ratio = 8'(DIV_RATIO_3 - 1);
    endcase
  end

  // Divider runs only during a conversion, so each one starts aligned
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
    end else if (state != adc_conv_pkg::st_conv || conv_tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign conv_tick = (state == adc_conv_pkg::st_conv) && (div_cnt >= div_ratio);

  // ---------------------------------------------------------------
  // Comparator synchroniser
  // ---------------------------------------------------------------
  // Comparator output is asynchronous to mclk
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= cmp_in;
      cmp_sync <= cmp_meta;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Start falling edge detect on the register bit itself
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= start_bit;
    end
  end

  assign finish = conv_tick && (tick_cnt == `ADC_TICK_LAST);

  // Start held high always wins; powering down aborts a conversion
  always_comb begin
    next_state = state;
    case (state)
      adc_conv_pkg::st_idle: begin
        if (start_bit) begin
          next_state = adc_conv_pkg::st_hold;
        end
      end
      adc_conv_pkg::st_hold: begin
        if (!start_bit && start_prev && powered) begin
          next_state = adc_conv_pkg::st_conv;
        end else if (!start_bit) begin
          next_state = adc_conv_pkg::st_idle;
        end
      end
      adc_conv_pkg::st_conv: begin
        if (start_bit) begin
          next_state = adc_conv_pkg::st_hold;
        end else if (!powered || finish) begin
          next_state = adc_conv_pkg::st_idle;
        end
      end
      default: begin
        next_state = adc_conv_pkg::st_idle;
      end
    endcase
  end

  // Runs beside the CPU; software keeps executing meanwhile
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= adc_conv_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Converter clock periods within one conversion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 4'h0;
    end else if (state != adc_conv_pkg::st_conv) begin
      tick_cnt <= 4'h0;
    end else if (conv_tick) begin
      tick_cnt <= tick_cnt + 4'h1;
    end
  end

  // Successive approximation: keep or drop each trial bit, MSB first.
  // A full period separates trial set-up and decision, which covers
  // the DAC settling and the two-flop comparator latency.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trial   <= 12'h000;
      bit_idx <= `ADC_RES_MSB;
    end else if (state != adc_conv_pkg::st_conv) begin
      trial   <= 12'h000;
      bit_idx <= `ADC_RES_MSB;
    end else if (conv_tick) begin
      if (tick_cnt == `ADC_TICK_SAMPLE) begin
        trial[`ADC_RES_MSB] <= 1'b1;
      end else if (tick_cnt >= `ADC_TICK_MSB && tick_cnt <= `ADC_TICK_LSB - 4'h1) begin
        trial[bit_idx] <= cmp_sync;
        trial[bit_idx - 4'h1] <= 1'b1;
        bit_idx <= bit_idx - 4'h1;
      end else if (tick_cnt == `ADC_TICK_LSB) begin
        trial[bit_idx] <= cmp_sync;
      end
    end
  end

  // Result latched on the same edge as the done flag falls
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result <= `ADC_RST_RESULT;
    end else if (finish && !start_bit) begin
      result <= trial;
    end
  end

  // End-of-conversion flag: forced high by start, low on completion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conv_done_n <= `ADC_RST_DONE_N;
    end else if (start_bit) begin
      conv_done_n <= 1'b1;
    end else if (finish && state == adc_conv_pkg::st_conv) begin
      conv_done_n <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Completion request
  // ---------------------------------------------------------------
  // Write one to clear; a completion in the same cycle wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_flag   <= 1'b0;
      irq_enable <= 1'b0;
    end else begin
      if (finish && !start_bit) begin
        irq_flag <= 1'b1;
      end else if (wr_access && paddr == `ADC_OFS_IRQ && pwdata[`ADC_IRQ_FLAG]) begin
        irq_flag <= 1'b0;
      end
      if (wr_access && paddr == `ADC_OFS_IRQ) begin
        irq_enable <= pwdata[`ADC_IRQ_ENABLE];
      end
    end
  end

  // Level request, held until software clears the flag
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= irq_flag & irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // Converter macro drive
  // ---------------------------------------------------------------
  // Reset held while start is high; sampling in the first period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conv_drive <= '{power_down: 1'b1, reset: 1'b1, sample: 1'b0, dac_code: 12'h000};
    end else begin
      conv_drive.power_down <= ~powered;
      conv_drive.reset      <= start_bit | (next_state != adc_conv_pkg::st_conv);
      conv_drive.sample     <= (next_state == adc_conv_pkg::st_conv) &&
                               (state != adc_conv_pkg::st_conv ||
                                tick_cnt == `ADC_TICK_SAMPLE && !conv_tick);
      conv_drive.dac_code   <= trial;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/adc_conversion_control_chk.sv ====
// Port-level assertions for the conversion control block.
// Assumes it is bound into adc_conversion_control and sees only its ports.
`timescale 1ns/10ps
`include "adc_conv_map.svh"
`default_nettype none

module adc_conversion_control_chk #(
  parameter int DIV_RATIO_0 = 4,
  parameter int DIV_RATIO_3 = 32
) (
  // Clock and reset
  input wire logic                      mclk,
  input wire logic                      resetn,
  // APB slave
  input wire logic [`ADC_APB_AW-1:0]    paddr,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [31:0]               pwdata,
  input wire logic [3:0]                pstrb,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Converter and pins
  input wire adc_conv_pkg::conv_drive_t conv_drive,
  input wire logic [15:0]               channel_route,
  input wire adc_conv_pkg::pin_drive_t  pin_drive
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  localparam int MIN_LEN = 16 * DIV_RATIO_0 - 2;
  localparam int MAX_LEN = 16 * DIV_RATIO_3 + 4;
  logic [11:0] len;
  logic        cut;
  logic        wr_acc;
  logic        unmapped;
  assign wr_acc = psel && penable && pwrite && pstrb[0];
  assign unmapped = !(paddr inside {`ADC_OFS_CTRL, `ADC_OFS_SELECT, `ADC_OFS_RES_HIGH,
                                    `ADC_OFS_RES_LOW, `ADC_OFS_IRQ});

  // Cycles out of converter reset; control writes may cut a run short
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      len <= 12'h000;
      cut <= 1'b0;
    end else if (conv_drive.reset) begin
      len <= 12'h000;
      cut <= 1'b0;
    end else begin
      len <= len + 12'h001;
      if (wr_acc && (paddr == `ADC_OFS_CTRL || paddr == `ADC_OFS_SELECT)) begin
        cut <= 1'b1;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence wr_sel_s(logic [3:0] code);
    wr_acc && paddr == `ADC_OFS_SELECT && pwdata[7:4] == code;
  endsequence
  sequence wr_start_s;
    wr_acc && paddr == `ADC_OFS_CTRL && pwdata[`ADC_CTRL_START];
  endsequence
  sequence conv_end_s;
    $rose(conv_drive.reset) && !cut;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  route_onehot_a: assert property ($onehot0(channel_route))
    else $error("analog route not one-hot");
  start_reset_a: assert property (wr_start_s |-> ##[1:2] conv_drive.reset)
    else $error("start high did not reset converter");
  all_analog_a: assert property (wr_sel_s(4'hf) |-> ##[1:2] pin_drive.analog_en == 16'hffff)
    else $error("config ones did not make all pins analog");
  pins_off_a: assert property (wr_sel_s(4'h0) |-> ##[1:2]
    (pin_drive == '0 && conv_drive.power_down && channel_route == 16'h0))
    else $error("config zero left pins analog or converter powered");
  pull_cut_a: assert property (pin_drive.pullup_cut == pin_drive.analog_en)
    else $error("pull-high cut differs from analog mask");
  dir_force_a: assert property (pin_drive.dir_force_in == pin_drive.analog_en)
    else $error("direction override differs from analog mask");
  pin_contig_a: assert property ((pin_drive.analog_en & (pin_drive.analog_en + 16'h1)) == 16'h0)
    else $error("analog pin set not contiguous from pin 0");
  conv_min_a: assert property (conv_end_s |-> len >= MIN_LEN)
    else $error("conversion ended too early");
  conv_max_a: assert property (len <= MAX_LEN)
    else $error("conversion ran too long");
  result_low_a: assert property (psel && !penable && !pwrite && paddr == `ADC_OFS_RES_LOW
    |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
    else $error("low result register has stray bits");
  bad_addr_a: assert property (psel && penable && unmapped |->
    pslverr && pready && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
endmodule

bind adc_conversion_control adc_conversion_control_chk #(
  .DIV_RATIO_0(DIV_RATIO_0),
  .DIV_RATIO_3(DIV_RATIO_3)
) u_chk (
  .mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conv_drive(conv_drive), .channel_route(channel_route),
  .pin_drive(pin_drive)
);
`default_nettype wire

// ==== testbench/tb_adc_conversion_control.sv ====
// Self-checking bench for the conversion control block.
// Assumes the bench plays APB master and the analog comparator itself.
`timescale 1ns/10ps
`include "adc_conv_map.svh"
`default_nettype none

module tb_adc_conversion_control;
  localparam int RAT [4] = '{4, 8, 16, 32};
  logic                      mclk, resetn, psel, penable, pwrite, pready, pslverr, cmp_in, conv_irq;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, rdv;
  logic [3:0]                pstrb;
  logic [15:0]               channel_route;
  logic [11:0]               vin;
  logic                      err;
  adc_conv_pkg::conv_drive_t conv_drive;
  adc_conv_pkg::pin_drive_t  pin_drive;
  int                        cyc, num_errors, cmp_count, t;

  adc_conversion_control #(.DIV_RATIO_0(RAT[0]), .DIV_RATIO_1(RAT[1]), .DIV_RATIO_2(RAT[2]),
    .DIV_RATIO_3(RAT[3]), .PIN_STEP(1)) dut (
    .mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_in(cmp_in), .conv_drive(conv_drive),
    .channel_route(channel_route), .pin_drive(pin_drive), .conv_irq(conv_irq));

  // Clock; the ideal comparator follows the trial code
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Comparator is asynchronous; the design's own synchroniser adds the latency
  assign cmp_in = (vin >= conv_drive.dac_code);

  // Hang guard, far above the longest sequence
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hf;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done(output int tt);
    rdv = 32'h80;
    while (rdv[7] !== 1'b0) apb(1'b0, `ADC_OFS_CTRL, 32'h0, rdv, err);
    tt = cyc;
  endtask
  function automatic logic [15:0] mask_of(input int n);
    return (n == 15) ? 16'hffff : 16'((17'h1 << n) - 17'h1);
  endfunction
  task automatic conv(input int dv, input int ch, input logic [11:0] v, input logic ien);
    int t0;
    vin = v;
    apb(1'b1, `ADC_OFS_SELECT, 32'hf0 | 32'(dv), rdv, err);
    apb(1'b1, `ADC_OFS_IRQ, {30'h0, ien, 1'b1}, rdv, err);
    apb(1'b1, `ADC_OFS_CTRL, 32'h40 | 32'(ch), rdv, err);
    apb(1'b0, `ADC_OFS_CTRL, 32'h0, rdv, err);
    chk(rdv[7], 1'b1);
    chk(conv_drive.reset, 1'b1);
    apb(1'b1, `ADC_OFS_CTRL, 32'(ch), rdv, err);
    t0 = cyc;
    wait_done(t);
    chk(t - t0 >= 16 * RAT[dv] - 1 && t - t0 <= 16 * RAT[dv] + 8, 1'b1);
    chk(channel_route, 16'h1 << ch);
    apb(1'b0, `ADC_OFS_RES_HIGH, 32'h0, rdv, err);
    chk(rdv, {24'h0, v[11:4]});
    apb(1'b0, `ADC_OFS_RES_LOW, 32'h0, rdv, err);
    chk(rdv, {24'h0, v[3:0], 4'h0});
    apb(1'b0, `ADC_OFS_IRQ, 32'h0, rdv, err);
    chk(rdv, {30'h0, ien, 1'b1});
    chk(conv_irq, ien);
    apb(1'b1, `ADC_OFS_IRQ, {30'h0, ien, 1'b1}, rdv, err);
    repeat (2) @(posedge mclk);
    chk(conv_irq, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, err} = '0;
    {paddr, pwdata, pstrb, rdv, vin} = '0;
    {num_errors, cmp_count, t} = '0;
    void'($urandom(32'h49a0));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    // Reset values, then a refused access
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, rdv, err);
      chk(rdv, (i == 0) ? 32'h80 : (i == 1) ? 32'h03 : 32'h0);
    end
    chk(pin_drive, 48'h0);
    chk(conv_drive.power_down, 1'b1);
    apb(1'b1, 8'h14, 32'hff, rdv, err);
    apb(1'b0, 8'h14, 32'h0, rdv, err);
    chk({err, rdv}, 33'h1_0000_0000);
    // Every pin configuration code
    for (int n = 0; n < 16; n++) begin
      apb(1'b1, `ADC_OFS_SELECT, 32'(n << 4) | 32'h3, rdv, err);
      repeat (2) @(posedge mclk);
      chk(pin_drive, {3{mask_of(n)}});
      chk(conv_drive.power_down, n == 0);
    end
    // Corner codes, then random ones
    conv(0, 15, 12'h000, 1'b1); // Ideal comparator has no period floor
    conv(1, 0, 12'hfff, 1'b0);
    for (int k = 0; k < 6; k++) conv($urandom % 4, $urandom % 16, 12'($urandom), 1'($urandom));
    // Start raised mid-run: held in reset, no completion until released
    apb(1'b1, `ADC_OFS_CTRL, 32'h40, rdv, err);
    apb(1'b1, `ADC_OFS_CTRL, 32'h00, rdv, err);
    repeat (40) @(posedge mclk);
    apb(1'b1, `ADC_OFS_CTRL, 32'h40, rdv, err);
    repeat (600) @(posedge mclk);
    apb(1'b0, `ADC_OFS_CTRL, 32'h0, rdv, err);
    chk({rdv[7], conv_drive.reset}, 2'b11);
    apb(1'b1, `ADC_OFS_CTRL, 32'h00, rdv, err);
    wait_done(t);
    // Config cleared mid-run: powered down, no completion
    apb(1'b1, `ADC_OFS_CTRL, 32'h40, rdv, err);
    apb(1'b1, `ADC_OFS_CTRL, 32'h00, rdv, err);
    repeat (40) @(posedge mclk);
    apb(1'b1, `ADC_OFS_SELECT, 32'h03, rdv, err); // No start pulse follows
    repeat (600) @(posedge mclk);
    apb(1'b0, `ADC_OFS_CTRL, 32'h0, rdv, err);
    chk({rdv[7], conv_drive.power_down}, 2'b11);
    conclude();
  end
endmodule
`default_nettype wire
